// ===== verilog/opc_ctrl.sv
// opc_ctrl: op-amp channel switch, comparator filter and event logic
// assumes AHB-Lite single word transfers and a 32 MHz RC clock on RC_CLK
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

// Function
// RQ1: switch counter doubles as 8-bit overflow timer
// RQ2: soft switch write causes one channel switch
// RQ3: ctrl A bit 6 reads selected channel
// RQ4: soft switches also get transition period
// RQ5: timer enable bit runs timer and interrupt
// RQ6: dual mode runs timer, interrupt stays gated
// RQ7: counter match starts switch and clears counter
// RQ8: transition count sets hold, zero disables
// RQ9: period register is scratch byte when disabled
// RQ10: reference select picks positive input source
// RQ11: two select bits pick negative input
// RQ12: output held during switch transition
// RQ13: filter enable bit, width from register
// RQ14: filter clock system or RC over 32
// RQ15: changes pass only after stable width
// RQ16: ctrl A channel enables and invert bits
// RQ17: module enable and channel mode decode
// RQ18: DAC code n gives (n+1)/256 reference
// RQ19: DAC pin output has own enable
// RQ20: comparator disable bit, status resets 0x80
// RQ21: status bit 5 is synchronized output
// RQ22: flag on event, gated interrupt, clears
// RQ23: event mode any, falling or rising
// RQ24: capture source comparator or capture pin
// RQ25: comparator output drives PWM shutdown
// RQ26: filter restarts count on differing sample
module opc_ctrl (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic HRESP,
    output logic [31:0] HRDATA,
    input wire logic RC_CLK,
    input wire logic COMP_RAW,
    input wire logic CAPTURE_PIN,
    input wire logic GLOBAL_IRQ_EN,
    input wire logic IRQ_ACK,
    output logic COMP_IRQ,
    output logic TIMER_IRQ,
    output logic FRONTEND_ON,
    output logic CHANNEL_SEL,
    output logic AMP_INVERT,
    output logic COMP_ON,
    output logic POS_SEL_REF,
    output logic [1:0] NEG_SEL,
    output logic [2:0] ADC_CHAN,
    output logic [7:0] DAC_CODE,
    output logic DAC_PIN_EN,
    output logic CAPTURE_OUT,
    output logic PWM_SHUTDOWN,
    output logic HOLD_ACTIVE
);
    // ****************************************
    // bus slave
    // ****************************************
    logic [7:0] status_q, ctrl_a_q, ctrl_b_q, period_q, asel_q, fwidth_q, dac_q;
    logic wr_q, rd_q;
    logic [7:0] idx_q;
    logic [7:0] wdat;
    logic wr_status, wr_a, soft_sw;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            idx_q <= 8'h00;
        end else begin
            wr_q <= HSEL & HTRANS[1] & HREADY & HWRITE;
            rd_q <= HSEL & HTRANS[1] & HREADY & ~HWRITE;
            if (HSEL & HTRANS[1] & HREADY) begin
                idx_q <= HADDR[9:2];
            end
        end
    end

    assign wdat = HWDATA[7:0];
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign wr_status = wr_q && idx_q == opc_pkg::IDX_STATUS;
    assign wr_a = wr_q && idx_q == opc_pkg::IDX_CTRL_A;
    assign soft_sw = wr_a & wdat[opc_pkg::B_SOFTSW]; // RQ2

    logic filt_q;
    logic chan_q;

    always_comb begin
        HRDATA = 32'h0000_0000;
        if (rd_q) begin
            case (idx_q)
                opc_pkg::IDX_STATUS: HRDATA[7:0] = {status_q[7:6], filt_q, status_q[4:0]}; // RQ21
                opc_pkg::IDX_CTRL_A: HRDATA[7:0] = {ctrl_a_q[7], chan_q, ctrl_a_q[5], 1'b0,
                                                    ctrl_a_q[3:0]}; // RQ3
                opc_pkg::IDX_CTRL_B: HRDATA[7:0] = ctrl_b_q;
                opc_pkg::IDX_PERIOD: HRDATA[7:0] = period_q; // RQ9
                opc_pkg::IDX_ASEL: HRDATA[7:0] = asel_q;
                opc_pkg::IDX_FWIDTH: HRDATA[7:0] = fwidth_q;
                opc_pkg::IDX_DAC: HRDATA[7:0] = dac_q;
                default: HRDATA = 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    logic event_w;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            ctrl_a_q <= opc_pkg::RST_CTRL_A;
            ctrl_b_q <= opc_pkg::RST_CTRL_B;
            period_q <= opc_pkg::RST_PERIOD;
            asel_q <= opc_pkg::RST_ASEL;
            fwidth_q <= opc_pkg::RST_FWIDTH;
            dac_q <= opc_pkg::RST_DAC;
        end else if (wr_q) begin
            case (idx_q)
                opc_pkg::IDX_CTRL_A: ctrl_a_q <= {wdat[7], 1'b0, wdat[5], 1'b0, wdat[3:0]}; // RQ16
                opc_pkg::IDX_CTRL_B: ctrl_b_q <= wdat;
                opc_pkg::IDX_PERIOD: period_q <= wdat; // RQ9
                opc_pkg::IDX_ASEL: asel_q <= wdat;
                opc_pkg::IDX_FWIDTH: fwidth_q <= wdat;
                opc_pkg::IDX_DAC: dac_q <= wdat;
                default: ctrl_a_q <= ctrl_a_q;
            endcase
        end
    end

    // flag set wins over a clear in the same cycle
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            status_q <= opc_pkg::RST_STATUS; // RQ20
        end else begin
            if (wr_status) begin
                status_q[7:6] <= wdat[7:6];
                status_q[3:0] <= wdat[3:0];
            end
            status_q[5] <= 1'b0;
            if (event_w) begin
                status_q[4] <= 1'b1; // RQ22
            end else if (IRQ_ACK || (wr_status && wdat[opc_pkg::B_FLAG])) begin
                status_q[4] <= 1'b0; // RQ22
            end
        end
    end

    // ****************************************
    // synchronisers and RC tick
    // ****************************************
    logic [2:0] rc_s;
    logic [1:0] cmp_s, cap_s;
    logic [4:0] rc_div_q;
    logic rc_tick;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            rc_s <= 3'h0;
            cmp_s <= 2'h0;
            cap_s <= 2'h0;
            rc_div_q <= 5'h00;
        end else begin
            rc_s <= {rc_s[1:0], RC_CLK};
            cmp_s <= {cmp_s[0], COMP_RAW};
            cap_s <= {cap_s[0], CAPTURE_PIN};
            if (rc_s[1] & ~rc_s[2]) begin
                rc_div_q <= rc_div_q + 5'h01;
            end
        end
    end

    assign rc_tick = rc_s[1] & ~rc_s[2] & (rc_div_q == opc_pkg::RC_DIV_LAST); // RQ14

    logic tick;
    assign tick = asel_q[opc_pkg::B_FCLK] ? rc_tick : 1'b1; // RQ14

    // ****************************************
    // channel switching
    // ****************************************
    logic mod_en, dual, timer_run, tmr_match, sw_req;
    logic [7:0] tcnt_q;
    logic [6:0] trans_q;

    assign mod_en = ctrl_a_q[7]; // RQ17
    assign dual = mod_en & ctrl_a_q[0] & ctrl_a_q[1]; // RQ17
    assign timer_run = ctrl_b_q[opc_pkg::B_TEN] | dual; // RQ5 RQ6
    assign tmr_match = timer_run && tick && tcnt_q == period_q;
    assign sw_req = dual & (tmr_match | soft_sw); // RQ2 RQ7

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            tcnt_q <= 8'h00;
        end else if (!timer_run) begin
            tcnt_q <= 8'h00;
        end else if (tmr_match) begin
            tcnt_q <= 8'h00; // RQ7
        end else if (tick) begin
            tcnt_q <= tcnt_q + 8'h01; // RQ1
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            TIMER_IRQ <= 1'b0;
        end else begin
            TIMER_IRQ <= tmr_match & ctrl_b_q[opc_pkg::B_TEN]; // RQ1 RQ5 RQ6
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            chan_q <= 1'b0;
        end else if (!dual) begin
            chan_q <= mod_en & ctrl_a_q[1] & ~ctrl_a_q[0]; // RQ17
        end else if (sw_req) begin
            chan_q <= ~chan_q; // RQ2 RQ7
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            trans_q <= 7'h00;
        end else if (sw_req) begin
            trans_q <= ctrl_b_q[6:0]; // RQ4 RQ8
        end else if (trans_q != 7'h00 && tick) begin
            trans_q <= trans_q - 7'h01;
        end
    end

    assign HOLD_ACTIVE = trans_q != 7'h00; // RQ8

    // ****************************************
    // output hold and width filter
    // ****************************************
    logic held_q, cand_q;
    logic [7:0] fcnt_q;
    logic cmp_on, prev_q;

    assign cmp_on = ~status_q[opc_pkg::B_DIS]; // RQ20

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            held_q <= 1'b0;
        end else if (!HOLD_ACTIVE) begin
            held_q <= cmp_s[1] & cmp_on; // RQ12
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            cand_q <= 1'b0;
            fcnt_q <= 8'h00;
            filt_q <= 1'b0;
        end else if (!ctrl_a_q[opc_pkg::B_FEN]) begin
            cand_q <= held_q;
            fcnt_q <= 8'h00;
            filt_q <= held_q; // RQ13
        end else if (held_q != cand_q) begin
            cand_q <= held_q;
            fcnt_q <= 8'h00; // RQ26
        end else if (tick) begin
            if (fcnt_q == fwidth_q) begin
                filt_q <= cand_q; // RQ13 RQ15
            end else begin
                fcnt_q <= fcnt_q + 8'h01; // RQ15
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= filt_q;
        end
    end

    always_comb begin
        case (status_q[1:0])
            opc_pkg::EV_ANY: event_w = filt_q ^ prev_q; // RQ23
            opc_pkg::EV_FALL: event_w = prev_q & ~filt_q; // RQ23
            opc_pkg::EV_RISE: event_w = filt_q & ~prev_q; // RQ23
            default: event_w = 1'b0;
        endcase
    end

    // ****************************************
    // output routing
    // ****************************************
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            COMP_IRQ <= 1'b0;
            CAPTURE_OUT <= 1'b0;
            PWM_SHUTDOWN <= 1'b0;
            NEG_SEL <= opc_pkg::NEG_NONE;
        end else begin
            COMP_IRQ <= status_q[4] & status_q[opc_pkg::B_IE] & GLOBAL_IRQ_EN; // RQ22
            CAPTURE_OUT <= status_q[opc_pkg::B_CAPSEL] ? filt_q : cap_s[1]; // RQ24
            PWM_SHUTDOWN <= filt_q; // RQ25
            if (asel_q[1]) begin
                NEG_SEL <= opc_pkg::NEG_AMP; // RQ11
            end else if (asel_q[0]) begin
                NEG_SEL <= opc_pkg::NEG_ADC; // RQ11
            end else if (asel_q[opc_pkg::B_PINDIS]) begin
                NEG_SEL <= opc_pkg::NEG_PIN; // RQ11
            end else begin
                NEG_SEL <= opc_pkg::NEG_ADC;
            end
        end
    end

    assign FRONTEND_ON = mod_en; // RQ17
    assign CHANNEL_SEL = chan_q;
    assign AMP_INVERT = chan_q ? ctrl_a_q[3] : ctrl_a_q[2]; // RQ16
    assign COMP_ON = cmp_on;
    assign POS_SEL_REF = status_q[opc_pkg::B_REFSEL]; // RQ10
    assign ADC_CHAN = asel_q[4:2]; // RQ11
    assign DAC_CODE = dac_q; // RQ18
    assign DAC_PIN_EN = asel_q[opc_pkg::B_DACPIN]; // RQ19

    // ****************************************
    // checks
    // ****************************************
    soft_flip_a: assert property (@(posedge CLOCK) disable iff (RST) // RQ2
        sw_req |=> chan_q != $past(chan_q)) else $error("switch did not flip channel");
    timer_wrap_a: assert property (@(posedge CLOCK) disable iff (RST) // RQ7
        tmr_match |=> tcnt_q == 8'h00) else $error("counter not cleared on match");
    timer_irq_a: assert property (@(posedge CLOCK) disable iff (RST) // RQ6
        TIMER_IRQ |-> $past(ctrl_b_q[7]) && $past(tcnt_q) == $past(period_q))
        else $error("timer interrupt without enable or match");
    hold_out_a: assert property (@(posedge CLOCK) disable iff (RST) // RQ12
        HOLD_ACTIVE |=> held_q == $past(held_q)) else $error("output moved during hold");
    trans_zero_a: assert property (@(posedge CLOCK) disable iff (RST) // RQ8
        sw_req && ctrl_b_q[6:0] == 7'h00 |=> !HOLD_ACTIVE) else $error("hold with zero count");
    flag_set_a: assert property (@(posedge CLOCK) disable iff (RST) // RQ22
        event_w |=> status_q[4]) else $error("event lost");
    irq_gate_a: assert property (@(posedge CLOCK) disable iff (RST) // RQ22
        COMP_IRQ |-> $past(status_q[4] && status_q[3] && GLOBAL_IRQ_EN))
        else $error("interrupt not gated");
    reset_val_a: assert property (@(posedge CLOCK) // RQ20
        RST |=> status_q == 8'h80) else $error("status reset value wrong");
    filt_restart_a: assert property (@(posedge CLOCK) disable iff (RST) // RQ26
        ctrl_a_q[5] && held_q != cand_q |=> fcnt_q == 8'h00) else $error("filter not restarted");
endmodule : opc_ctrl

`default_nettype wire

// ===== verilog/opc_pkg.sv
// opc_pkg: register indices, field positions and reset values
// assumes a 32-bit bus; byte address of a register is four times its index
package opc_pkg;
    localparam logic [7:0] IDX_STATUS = 8'h2F;
    localparam logic [7:0] IDX_CTRL_A = 8'h32;
    localparam logic [7:0] IDX_CTRL_B = 8'h33;
    localparam logic [7:0] IDX_PERIOD = 8'h34;
    localparam logic [7:0] IDX_ASEL = 8'h35;
    localparam logic [7:0] IDX_FWIDTH = 8'h36;
    localparam logic [7:0] IDX_DAC = 8'h37;
    localparam logic [7:0] RST_STATUS = 8'h80;
    localparam logic [7:0] RST_CTRL_A = 8'h00;
    localparam logic [7:0] RST_CTRL_B = 8'h07;
    localparam logic [7:0] RST_PERIOD = 8'h00;
    localparam logic [7:0] RST_ASEL = 8'h00;
    localparam logic [7:0] RST_FWIDTH = 8'hFF;
    localparam logic [7:0] RST_DAC = 8'hFF;
    localparam int B_DIS = 7;
    localparam int B_REFSEL = 6;
    localparam int B_OUT = 5;
    localparam int B_FLAG = 4;
    localparam int B_IE = 3;
    localparam int B_CAPSEL = 2;
    localparam int B_SOFTSW = 6;
    localparam int B_FEN = 5;
    localparam int B_TEN = 7;
    localparam int B_FCLK = 6;
    localparam int B_DACPIN = 7;
    localparam int B_PINDIS = 5;
    localparam logic [4:0] RC_DIV_LAST = 5'h1F;
    localparam logic [1:0] EV_ANY = 2'h0;
    localparam logic [1:0] EV_FALL = 2'h2;
    localparam logic [1:0] EV_RISE = 2'h3;
    localparam logic [1:0] NEG_PIN = 2'h0;
    localparam logic [1:0] NEG_ADC = 2'h1;
    localparam logic [1:0] NEG_AMP = 2'h2;
    localparam logic [1:0] NEG_NONE = 2'h3;
endpackage : opc_pkg

// ===== tb/tb.sv
// tb: self-checking bench for opc_ctrl, random register and comparator traffic
// assumes opc_pkg and opc_ctrl are compiled first; one AHB-Lite master, no partner
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic CLOCK = 1'b0;
    logic RST = 1'b1;
    logic HSEL = 1'b0;
    logic [31:0] HADDR = 32'h0;
    logic [1:0] HTRANS = 2'h0;
    logic HWRITE = 1'b0;
    logic [31:0] HWDATA = 32'h0;
    logic RC_CLK = 1'b0;
    logic COMP_RAW = 1'b0;
    logic CAPTURE_PIN = 1'b0;
    logic GLOBAL_IRQ_EN = 1'b0;
    logic IRQ_ACK = 1'b0;
    logic HREADY, HRESP, COMP_IRQ, TIMER_IRQ, FRONTEND_ON, CHANNEL_SEL, AMP_INVERT;
    logic COMP_ON, POS_SEL_REF, DAC_PIN_EN, CAPTURE_OUT, PWM_SHUTDOWN, HOLD_ACTIVE;
    logic [31:0] HRDATA;
    logic [1:0] NEG_SEL;
    logic [2:0] ADC_CHAN;
    logic [7:0] DAC_CODE;
    logic [7:0] amodes [4] = '{8'h80, 8'h85, 8'h8A, 8'hAE};
    logic [1:0] evm [4] = '{opc_pkg::EV_ANY, 2'h1, opc_pkg::EV_FALL, opc_pkg::EV_RISE};
    int error_cnt = 0;
    int checks_done = 0;

    opc_ctrl opc_ctrl_inst (
        .CLOCK(CLOCK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADY),
        .HREADYOUT(HREADY), .HRESP(HRESP), .HRDATA(HRDATA), .RC_CLK(RC_CLK),
        .COMP_RAW(COMP_RAW), .CAPTURE_PIN(CAPTURE_PIN), .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN),
        .IRQ_ACK(IRQ_ACK), .COMP_IRQ(COMP_IRQ), .TIMER_IRQ(TIMER_IRQ),
        .FRONTEND_ON(FRONTEND_ON), .CHANNEL_SEL(CHANNEL_SEL), .AMP_INVERT(AMP_INVERT),
        .COMP_ON(COMP_ON), .POS_SEL_REF(POS_SEL_REF), .NEG_SEL(NEG_SEL),
        .ADC_CHAN(ADC_CHAN), .DAC_CODE(DAC_CODE), .DAC_PIN_EN(DAC_PIN_EN),
        .CAPTURE_OUT(CAPTURE_OUT), .PWM_SHUTDOWN(PWM_SHUTDOWN), .HOLD_ACTIVE(HOLD_ACTIVE)
    );

    always #5 CLOCK = ~CLOCK;
    // roughly 32 MHz, unrelated in phase to the system clock
    always #15.6 RC_CLK = ~RC_CLK;

    // ****************************************************************
    // bus, compare and expectation helpers
    // ****************************************************************
    task automatic print_verdict();
        $display("errors %0d, checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string w);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, w, got, exp);
        end
    endtask : chk_reg

    task automatic chk_bit(input logic got, input logic exp, input string w);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t %s got %b exp %b", $time, w, got, exp);
        end
    endtask : chk_bit

    task automatic cyc(input int n);
        repeat (n) @(posedge CLOCK);
    endtask : cyc

    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd);
        @(posedge CLOCK);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= {22'h0, idx, 2'h0};
        HWRITE <= wr;
        do @(posedge CLOCK); while (HREADY !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= {24'h0, wd};
        do @(posedge CLOCK); while (HREADY !== 1'b1);
        rd = HRDATA[7:0];
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, idx, d, x);
    endtask : wr

    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp, input string w);
        logic [7:0] x;
        bus(1'b0, idx, 8'h00, x);
        chk_reg(x, exp, w);
        chk_bit(HRESP, 1'b0, "bus response");
    endtask : rdc

    task automatic glitch();
        COMP_RAW <= 1'b1;
        cyc(2);
        COMP_RAW <= 1'b0;
        cyc(30);
    endtask : glitch

    function automatic logic exp_flag(input logic [1:0] md, input logic lvl);
        return md == opc_pkg::EV_ANY || (md == opc_pkg::EV_RISE && lvl)
            || (md == opc_pkg::EV_FALL && !lvl);
    endfunction : exp_flag

    function automatic logic [1:0] exp_neg(input logic [7:0] a);
        if (a[1]) begin
            return opc_pkg::NEG_AMP;
        end
        return (a[0] || !a[opc_pkg::B_PINDIS]) ? opc_pkg::NEG_ADC : opc_pkg::NEG_PIN;
    endfunction : exp_neg

    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        repeat (50000) @(posedge CLOCK);
        error_cnt++;
        print_verdict();
    end

    initial begin
        logic [7:0] v;
        logic [1:0] m;
        int n;
        int p;
        void'($urandom(95148));
        repeat (16) @(posedge CLOCK);
        RST <= 1'b0;
        rdc(opc_pkg::IDX_STATUS, 8'h80, "status reset");
        rdc(opc_pkg::IDX_CTRL_A, 8'h00, "ctrl_a reset");
        rdc(opc_pkg::IDX_CTRL_B, 8'h07, "ctrl_b reset");
        rdc(opc_pkg::IDX_PERIOD, 8'h00, "period reset");
        rdc(opc_pkg::IDX_DAC, 8'hFF, "dac reset");
        chk_bit(COMP_ON, 1'b0, "comparator off");
        wr(8'h00, 8'h5A);
        rdc(8'h00, 8'h00, "unmapped");
        wr(opc_pkg::IDX_STATUS, 8'hA0);
        rdc(opc_pkg::IDX_STATUS, 8'h80, "read-only out bit");
        v = 8'($urandom);
        wr(opc_pkg::IDX_PERIOD, v);
        rdc(opc_pkg::IDX_PERIOD, v, "scratch byte");
        foreach (amodes[i]) begin
            v = amodes[i];
            wr(opc_pkg::IDX_CTRL_A, v);
            cyc(2);
            m[0] = v[1:0] == 2'b10;
            chk_bit(FRONTEND_ON, v[7], "frontend");
            chk_bit(CHANNEL_SEL, m[0], "single channel");
            chk_bit(AMP_INVERT, m[0] ? v[3] : v[2], "invert");
            rdc(opc_pkg::IDX_CTRL_A, {v[7], m[0], v[5], 1'b0, v[3:0]}, "chan read");
        end
        for (int j = 0; j < 8; j++) begin
            v = {1'($urandom), 1'b0, j[2], 3'($urandom), j[1:0]};
            p = $urandom;
            wr(opc_pkg::IDX_ASEL, v);
            wr(opc_pkg::IDX_DAC, 8'(p));
            cyc(2);
            chk_reg({6'h0, NEG_SEL}, {6'h0, exp_neg(v)}, "neg select");
            chk_reg({5'h0, ADC_CHAN}, {5'h0, v[4:2]}, "adc chan");
            chk_bit(DAC_PIN_EN, v[7], "dac pin");
            chk_reg(DAC_CODE, 8'(p), "dac code");
        end
        wr(opc_pkg::IDX_ASEL, 8'h00);
        wr(opc_pkg::IDX_CTRL_A, 8'h00);
        p = $urandom_range(40, 3);
        wr(opc_pkg::IDX_PERIOD, 8'(p));
        wr(opc_pkg::IDX_CTRL_B, 8'h87);
        n = 0;
        while (TIMER_IRQ !== 1'b1 && n < 300) begin
            cyc(1);
            n++;
        end
        cyc(1);
        n = 1;
        while (TIMER_IRQ !== 1'b1 && n < 300) begin
            cyc(1);
            n++;
        end
        chk_reg(8'(n), 8'(p + 1), "timer period");
        wr(opc_pkg::IDX_CTRL_B, 8'h00);
        wr(opc_pkg::IDX_PERIOD, 8'h05);
        wr(opc_pkg::IDX_CTRL_A, 8'h83);
        n = 0;
        p = 0;
        v[0] = CHANNEL_SEL;
        repeat (60) begin
            cyc(1);
            n += int'(CHANNEL_SEL !== v[0]);
            p += int'(TIMER_IRQ === 1'b1);
            v[0] = CHANNEL_SEL;
        end
        chk_bit(n >= 9 && n <= 11, 1'b1, "auto switching");
        chk_reg(8'(p), 8'h00, "dual irq gated");
        wr(opc_pkg::IDX_PERIOD, 8'hFF);
        for (int t = 0; t < 2; t++) begin
            wr(opc_pkg::IDX_CTRL_B, t ? 8'h00 : 8'h07);
            bus(1'b0, opc_pkg::IDX_CTRL_A, 8'h00, v);
            wr(opc_pkg::IDX_CTRL_A, 8'hC3);
            n = 0;
            repeat (20) begin
                cyc(1);
                n += int'(HOLD_ACTIVE === 1'b1);
            end
            chk_bit(t ? n == 0 : n >= 7 && n <= 9, 1'b1, "hold length");
            rdc(opc_pkg::IDX_CTRL_A, {1'b1, ~v[6], 6'h03}, "soft switch");
        end
        wr(opc_pkg::IDX_FWIDTH, 8'h03);
        wr(opc_pkg::IDX_CTRL_A, 8'h20);
        GLOBAL_IRQ_EN <= 1'b1;
        foreach (evm[i]) begin
            m = evm[i];
            wr(opc_pkg::IDX_STATUS, {6'b000110, m});
            cyc(1);
            chk_bit(COMP_ON, 1'b1, "comparator on");
            for (int e = 0; e < 2; e++) begin
                COMP_RAW <= ~COMP_RAW;
                CAPTURE_PIN <= 1'($urandom);
                cyc(30);
                v[0] = exp_flag(m, COMP_RAW);
                chk_bit(COMP_IRQ, v[0], "irq");
                chk_bit(PWM_SHUTDOWN, COMP_RAW, "shutdown");
                chk_bit(CAPTURE_OUT, CAPTURE_PIN, "capture pin");
                rdc(opc_pkg::IDX_STATUS, {2'b00, COMP_RAW, v[0], 2'b10, m}, "event");
                if (e == 0) begin
                    wr(opc_pkg::IDX_STATUS, {6'b000110, m});
                end else begin
                    IRQ_ACK <= 1'b1;
                    cyc(1);
                    IRQ_ACK <= 1'b0;
                end
                cyc(3);
                chk_bit(COMP_IRQ, 1'b0, "flag cleared");
            end
        end
        wr(opc_pkg::IDX_STATUS, 8'h5C);
        glitch();
        rdc(opc_pkg::IDX_STATUS, 8'h4C, "glitch dropped");
        chk_bit(POS_SEL_REF, 1'b1, "ref select");
        wr(opc_pkg::IDX_CTRL_A, 8'h00);
        glitch();
        rdc(opc_pkg::IDX_STATUS, 8'h5C, "filter off");
        COMP_RAW <= 1'b1;
        cyc(30);
        chk_bit(CAPTURE_OUT, 1'b1, "capture comp");
        wr(opc_pkg::IDX_ASEL, 8'h40);
        wr(opc_pkg::IDX_CTRL_A, 8'h20);
        COMP_RAW <= 1'b0;
        cyc(40);
        chk_bit(PWM_SHUTDOWN, 1'b1, "slow filter wait");
        cyc(800);
        chk_bit(PWM_SHUTDOWN, 1'b0, "slow filter pass");
        print_verdict();
    end
endmodule : tb
`default_nettype wire
